// ---- rtl/adsq_ctrl.sv ----
// Chosen here: the APB register port.
`timescale 1ns/1ps
// Functional notes
// - Eight completion flags, one per conversion.
// - Flags indexed by sequence position, not channel.
// - Compare-enabled position flags only on true compare.
// - Compare irq enable raises compare interrupt request.
// - Compare positions keep compare value, drop result.
// - Start register write restarts, clears all flags.
// - Normal clear: write one clears flag.
// - Fast clear, no compare: result read clears.
// - Fast clear, compare: result write clears.
// - Start clear beats set; other clears lose.
// - Configuration write aborts running sequence.
// - Bit 7 source type, bits 3-0 selection.
// - Absent trigger input: analog channel stays source.
// - Resolution 00 eight bit, 01 ten bit.
// - Discharge bit adds two sample cycles.
module adsq_ctrl (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire adsq_pkg::adsq_conv_type conv_i,
    input wire logic [3:0] trig_dedicated_i,
    input wire logic [15:0] trig_analog_i,
    output adsq_pkg::adsq_core_req_type core_req_o,
    output logic [3:0] sample_cycles_o,
    output logic ext_trig_o,
    output logic cmp_irq_o,
    output logic irq_o
);
    import adsq_pkg::*;

    // The record holds configuration, flags, sequencer
    // and the registered bus answer together.
    // One flop bank then carries every output, so no
    // output passes through a gate after its flop.
    // Eight result words are packed ten bits apiece.
    // A word doubles as the compare value for its
    // position while compare is on there.
    // Results are flops, not a memory: costly in area,
    // but reads take a single cycle.
    // All state of the block lives in this one record.
    typedef struct packed {
        adsq_state_type state;
        logic [7:0] cfg;
        logic [7:0] flags;
        logic [7:0] cmp_en;
        logic [7:0] cmp_gt;
        logic [3:0] seq_len;
        logic [2:0] pos;
        logic fast_clr;
        logic cmp_ie;
        logic [1:0] irq_stat;
        logic [1:0] irq_en;
        logic [79:0] results;
        logic [31:0] rdata;
        logic ready;
        logic slverr;
        adsq_core_req_type req;
        logic [3:0] smp_cycles;
        logic ext_trig;
        logic cmp_irq;
        logic irq;
    } adsq_regs_type;

    adsq_regs_type r;
    adsq_regs_type r_nxt;

    // A request is taken on the first edge that sees
    // psel and penable high with no answer pending.
    // The answer stands for exactly one cycle, and the
    // pending term stops a second take of one access.
    // The two low address bits are ignored.
    // Registers sit below 0x40 and results above it.
    // Access phase of a transfer; the slave answers in the second access cycle.
    logic access;
    logic wr;
    logic rd;
    logic [3:0] idx;
    logic in_result;
    logic [2:0] res_n;
    logic reg_space;

    assign access = psel_i & penable_i & ~r.ready;
    assign wr = access & pwrite_i;
    assign rd = access & ~pwrite_i;
    assign idx = paddr_i[5:2];
    assign in_result = (paddr_i[11:5] == ADSQ_RESULT_BASE[11:5]);
    assign res_n = paddr_i[4:2];
    assign reg_space = (paddr_i[11:6] == 6'h00);

    // Per-position compare outcome and result clear strobes.
    logic [7:0] set_vec;
    logic [7:0] rd_clr;
    logic [7:0] wr_clr;
    logic [7:0] cmp_hit;
    logic [9:0] conv_val;

    // The core always hands back ten bits.
    // Eight-bit mode drops the two low bits, keeping
    // one scale; software shifts for a plain byte.
    // Reserved codes keep all ten bits.
    // The compare sees the trimmed value as well.
    // Resolution trims the result: eight-bit mode zeroes the low bits.
    always_comb begin
        if (r.cfg[ADSQ_CFG_RES_LSB +: 2] == ADSQ_RES_8BIT) begin
            conv_val = {conv_i.data[9:2], 2'h0};
        end else begin
            conv_val = conv_i.data;
        end
    end

    // Each position owns a flag, a result word, a
    // compare enable and a compare direction.
    // A result counts only for the slot being
    // converted, so flags follow the sequence slot,
    // never the input channel.
    // With compare on, a flag sets only on a pass.
    // Fast clear strobes fire on the access edge.
    // One generate loop forms each position's set and clear terms.
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_pos
            logic [9:0] held;
            logic done_here;
            assign held = r.results[g*10 +: 10];
            assign done_here = conv_i.valid & r.state[2] & (r.pos == 3'(g));
            // Greater or less-or-equal against the stored compare value.
            assign cmp_hit[g] = r.cmp_gt[g] ? (conv_val > held) : (conv_val <= held);
            assign set_vec[g] = done_here & (~r.cmp_en[g] | cmp_hit[g]);
            assign rd_clr[g] = rd & in_result & (res_n == 3'(g)) & r.fast_clr
                & ~r.cmp_en[g];
            assign wr_clr[g] = wr & in_result & (res_n == 3'(g)) & r.fast_clr
                & r.cmp_en[g];
        end
    endgenerate

    // Every register takes its next value here.
    // Later assignments override earlier ones: that
    // is how start beats ordinary flag clears and how
    // a configuration write beats the sequencer.
    // Local strobes are cleared first: no latches.
    // Next-state logic for the whole block.
    always_comb begin
        logic start_wr;
        logic cfg_wr;
        logic [7:0] w1c;
        logic [7:0] clr;
        logic cmp_event;
        logic seq_event;
        logic last;
        logic sel_ok;
        start_wr = 1'b0;
        cfg_wr = 1'b0;
        w1c = 8'h00;
        clr = 8'h00;
        cmp_event = 1'b0;
        seq_event = 1'b0;
        last = 1'b0;
        sel_ok = 1'b0;
        r_nxt = r;
        r_nxt.ready = access;
        r_nxt.slverr = 1'b0;
        r_nxt.req.start = 1'b0;

        // Lane zero off drops the write; the compare
        // direction rides along with its enable word.
        // Unlisted indices swallow writes quietly.
        // Register writes decoded by index; only the low byte strobe gates them.
        if (wr && reg_space && pstrb_i[0]) begin
            case (idx)
                ADSQ_IDX_CFG: begin
                    r_nxt.cfg = pwdata_i[7:0];
                    cfg_wr = 1'b1;
                end
                ADSQ_IDX_START: begin
                    start_wr = 1'b1;
                    r_nxt.seq_len = pwdata_i[3:0];
                end
                ADSQ_IDX_CMPEN: begin
                    r_nxt.cmp_en = pwdata_i[7:0];
                    r_nxt.cmp_gt = pwdata_i[15:8];
                end
                ADSQ_IDX_FLAGS: begin
                    if (!r.fast_clr) begin
                        w1c = pwdata_i[7:0];
                    end
                end
                ADSQ_IDX_CTRL: begin
                    r_nxt.fast_clr = pwdata_i[ADSQ_CTRL_FAST_BIT];
                    r_nxt.cmp_ie = pwdata_i[ADSQ_CTRL_CMPIE_BIT];
                end
                ADSQ_IDX_IRQ_EN: begin
                    r_nxt.irq_en = pwdata_i[1:0];
                end
                default: begin
                    // Other indices ignore writes.
                end
            endcase
        end

        // Software may write a result word at any time.
        // With compare off, the next conversion simply
        // overwrites it.
        // Result registers: writes store a compare value.
        if (wr && in_result && pstrb_i[0]) begin
            r_nxt.results[res_n*10 +: 10] = pwdata_i[9:0];
        end

        // Conversion results land only where compare is off.
        if (conv_i.valid && r.state[2] && !r.cmp_en[r.pos]) begin
            r_nxt.results[r.pos*10 +: 10] = conv_val;
        end
        cmp_event = |(set_vec & r.cmp_en);

        // Priority, lowest first: hold, software clears,
        // the set from a finishing conversion, start.
        // A clear in the cycle of a set leaves the flag
        // up, so no completion is ever lost.
        // The start clear must win, or a stale flag could
        // pass for a result of the new sequence.
        // Set wins over ordinary clears; a start clears everything.
        clr = w1c | rd_clr | wr_clr;
        r_nxt.flags = (r.flags & ~clr) | set_vec;
        if (start_wr) begin
            r_nxt.flags = ADSQ_FLAGS_RST;
        end

        // Each step sends a one-cycle start to the core,
        // spends a cycle in sample, then waits in convert
        // for the result pulse.
        // A pulse outside convert is ignored, so work in
        // flight after an abort cannot set a flag.
        // Zero and one both mean a single conversion.
        // The walk also stops at the eighth slot, so an
        // oversized length cannot wrap and run forever.
        // Sequencer: sample then convert each position in turn.
        last = ({1'b0, r.pos} + 4'h1 >= r.seq_len) || (r.pos == 3'h7);
        case (r.state)
            ADSQ_IDLE: begin
                r_nxt.pos = 3'h0;
            end
            ADSQ_SAMPLE: begin
                r_nxt.state = ADSQ_CONVERT;
            end
            ADSQ_CONVERT: begin
                if (conv_i.valid) begin
                    if (last) begin
                        r_nxt.state = ADSQ_IDLE;
                        seq_event = 1'b1;
                    end else begin
                        r_nxt.pos = r.pos + 3'h1;
                        r_nxt.state = ADSQ_SAMPLE;
                        r_nxt.req.start = 1'b1;
                    end
                end
            end
            default: begin
                r_nxt.state = ADSQ_IDLE;
            end
        endcase
        r_nxt.req.channel = r_nxt.pos;
        if (start_wr) begin
            r_nxt.state = ADSQ_SAMPLE;
            r_nxt.pos = 3'h0;
            r_nxt.req.start = 1'b1;
            r_nxt.req.channel = 3'h0;
        end
        if (cfg_wr) begin
            r_nxt.state = ADSQ_IDLE;
            r_nxt.req.start = 1'b0;
        end

        // These use the value the configuration holds
        // after this edge, so the next start already
        // carries the new settings.
        // Discharge costs two sample cycles but helps to
        // spot an open input.
        // Core request and sample length follow the configuration.
        r_nxt.req.discharge = r_nxt.cfg[ADSQ_CFG_DISCH_BIT];
        r_nxt.req.ten_bit = (r_nxt.cfg[ADSQ_CFG_RES_LSB +: 2] == ADSQ_RES_10BIT);
        r_nxt.smp_cycles = r_nxt.cfg[ADSQ_CFG_DISCH_BIT] ? ADSQ_DISCH_CYCLES : 4'h0;

        // The source bit picks a dedicated input only when
        // the selection names one present in this build;
        // otherwise the bit is just stored.
        // The level is registered once and lags its pin
        // by a cycle; edge detection is the user's job.
        // Trigger source: a dedicated input only if it exists.
        sel_ok = (r.cfg[3:2] == 2'h0) && ADSQ_TRIG_PRESENT[r.cfg[1:0]];
        if (r.cfg[ADSQ_CFG_TRIG_SRC_BIT] && sel_ok) begin
            r_nxt.ext_trig = trig_dedicated_i[r.cfg[1:0]];
        end else begin
            r_nxt.ext_trig = trig_analog_i[r.cfg[3:0]];
        end

        // Events: end of sequence and a compare hit.
        // The clear word is write-one-to-clear, and an
        // event in the cycle of its clear wins.
        // The compare request is a one-cycle pulse with
        // its own enable, for users wanting an edge.
        // Interrupt status: sticky, set beats clear.
        if (wr && reg_space && idx == ADSQ_IDX_IRQ_CLR && pstrb_i[0]) begin
            r_nxt.irq_stat = r.irq_stat & ~pwdata_i[1:0];
        end
        r_nxt.irq_stat[ADSQ_EV_SEQ_DONE] = r_nxt.irq_stat[ADSQ_EV_SEQ_DONE] | seq_event;
        r_nxt.irq_stat[ADSQ_EV_CMP] = r_nxt.irq_stat[ADSQ_EV_CMP] | cmp_event;
        r_nxt.irq = |(r_nxt.irq_stat & r_nxt.irq_en);
        r_nxt.cmp_irq = cmp_event & r.cmp_ie;

        // Reads have no side effect except fast clear.
        // Outside both windows a read answers with an
        // error; unlisted register indices read zero.
        // Read data; reserved bits and unmapped words read zero.
        r_nxt.rdata = 32'h0000_0000;
        if (rd) begin
            if (in_result) begin
                r_nxt.rdata = {22'h0, r.results[res_n*10 +: 10]};
            end else if (reg_space) begin
                case (idx)
                    ADSQ_IDX_CFG: r_nxt.rdata = {24'h0, r.cfg};
                    ADSQ_IDX_FLAGS: r_nxt.rdata = {24'h0, r.flags};
                    ADSQ_IDX_START: r_nxt.rdata = {28'h0, r.seq_len};
                    ADSQ_IDX_CMPEN: r_nxt.rdata = {16'h0, r.cmp_gt, r.cmp_en};
                    ADSQ_IDX_CTRL: r_nxt.rdata = {30'h0, r.cmp_ie, r.fast_clr};
                    ADSQ_IDX_IRQ_STAT: r_nxt.rdata = {30'h0, r.irq_stat};
                    ADSQ_IDX_IRQ_EN: r_nxt.rdata = {30'h0, r.irq_en};
                    ADSQ_IDX_STATUS: r_nxt.rdata = {26'h0, r.pos, r.state};
                    default: r_nxt.rdata = 32'h0000_0000;
                endcase
            end else begin
                r_nxt.slverr = 1'b1;
            end
        end
        if (wr && !reg_space && !in_result) begin
            r_nxt.slverr = 1'b1;
        end
    end

    // Reset idles the sequencer and zeroes the rest.
    // The state takes its one-hot idle code, not zero.
    // The reset branch loads constants only, so no
    // data path is needed while reset is low.
    // Single register bank for the whole state record.
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            r <= '0;
            r.state <= ADSQ_IDLE;
            r.cfg <= ADSQ_CFG_RST;
            r.flags <= ADSQ_FLAGS_RST;
        end else begin
            r <= r_nxt;
        end
    end

    // No output passes through logic after its flop,
    // which keeps bus and core side free of glitches.
    // Read data is zero whenever no answer stands.
    // Outputs come straight from the state record.
    assign prdata_o = r.rdata;
    assign pready_o = r.ready;
    assign pslverr_o = r.slverr;
    assign core_req_o = r.req;
    assign sample_cycles_o = r.smp_cycles;
    assign ext_trig_o = r.ext_trig;
    assign cmp_irq_o = r.cmp_irq;
    assign irq_o = r.irq;
endmodule

// ---- rtl/adsq_pkg.sv ----
package adsq_pkg;
    // Register indices as printed; byte address is four times the index.
    localparam logic [3:0] ADSQ_IDX_CFG = 4'h1;
    localparam logic [3:0] ADSQ_IDX_FLAGS = 4'hA;
    // Registers of this block placed at free indices.
    localparam logic [3:0] ADSQ_IDX_START = 4'h5;
    localparam logic [3:0] ADSQ_IDX_CMPEN = 4'h8;
    localparam logic [3:0] ADSQ_IDX_CTRL = 4'hB;
    localparam logic [3:0] ADSQ_IDX_IRQ_STAT = 4'hC;
    localparam logic [3:0] ADSQ_IDX_IRQ_EN = 4'hD;
    localparam logic [3:0] ADSQ_IDX_IRQ_CLR = 4'hE;
    localparam logic [3:0] ADSQ_IDX_STATUS = 4'hF;
    localparam logic [3:0] ADSQ_IDX_RESULT0 = 4'h0;
    // Result registers live at byte address 0x40 + 4*n.
    localparam logic [11:0] ADSQ_RESULT_BASE = 12'h040;
    // Configuration field positions.
    localparam int ADSQ_CFG_TRIG_SRC_BIT = 7;
    localparam int ADSQ_CFG_RES_LSB = 5;
    localparam int ADSQ_CFG_DISCH_BIT = 4;
    // Control register fields: fast clear, compare irq enable.
    localparam int ADSQ_CTRL_FAST_BIT = 0;
    localparam int ADSQ_CTRL_CMPIE_BIT = 1;
    // Reset values.
    localparam logic [7:0] ADSQ_CFG_RST = 8'h00;
    localparam logic [7:0] ADSQ_FLAGS_RST = 8'h00;
    localparam logic [9:0] ADSQ_RESULT_RST = 10'h000;
    // Resolution codes.
    localparam logic [1:0] ADSQ_RES_8BIT = 2'h0;
    localparam logic [1:0] ADSQ_RES_10BIT = 2'h1;
    // Extra sample cycles when discharging first.
    localparam logic [3:0] ADSQ_DISCH_CYCLES = 4'h2;
    // Which dedicated trigger inputs are present in this build.
    localparam logic [3:0] ADSQ_TRIG_PRESENT = 4'hF;
    // Interrupt event bits.
    localparam int ADSQ_EV_SEQ_DONE = 0;
    localparam int ADSQ_EV_CMP = 1;

    // Sequencer states, one-hot.
    typedef enum logic [2:0] {
        ADSQ_IDLE = 3'b001,
        ADSQ_SAMPLE = 3'b010,
        ADSQ_CONVERT = 3'b100
    } adsq_state_type;

    // Result handed back by the analog core.
    typedef struct packed {
        logic valid;
        logic [9:0] data;
    } adsq_conv_type;

    // Request to the analog core.
    typedef struct packed {
        logic start;
        logic discharge;
        logic ten_bit;
        logic [2:0] channel;
    } adsq_core_req_type;
endpackage

// ---- test/adsq_ctrl_assertions.sv ----
`timescale 1ns/1ps
// Port-level checks on the bus answer and the converter-side requests.
module adsq_ctrl_chk (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire adsq_pkg::adsq_conv_type conv_i,
    input wire adsq_pkg::adsq_core_req_type core_req_o,
    input wire logic [3:0] sample_cycles_o,
    input wire logic cmp_irq_o
);
    import adsq_pkg::*;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    // An access phase that has not yet been answered.
    sequence s_wait;
        psel_i && penable_i && !pready_o;
    endsequence
    // A read that completes at this edge.
    sequence s_rd_done;
        pready_o && !pwrite_i;
    endsequence
    chk_ready_next: assert property (s_wait |=> pready_o)
        else $error("access not answered next cycle");
    chk_ready_pulse: assert property (pready_o |=> !pready_o)
        else $error("ready held too long");
    chk_err_ready: assert property (pslverr_o |-> pready_o && psel_i)
        else $error("error without ready");
    chk_flag_rsvd: assert property (s_rd_done ##0 paddr_i == 12'h028 |->
        prdata_o[31:8] == 24'h000000) else $error("flag upper bits set");
    chk_cfg_rsvd: assert property (s_rd_done ##0 paddr_i == 12'h004 |->
        prdata_o[31:8] == 24'h000000) else $error("config upper bits set");
    chk_disch_len: assert property (core_req_o.start |->
        sample_cycles_o == (core_req_o.discharge ? ADSQ_DISCH_CYCLES : 4'h0))
        else $error("sample length does not match discharge");
    chk_start_pulse: assert property (core_req_o.start |=> !core_req_o.start)
        else $error("sample request longer than one cycle");
    chk_cmp_cause: assert property (cmp_irq_o |->
        $past(conv_i.valid) || $past(conv_i.valid, 2)) else $error("compare irq without result");
endmodule

bind adsq_ctrl adsq_ctrl_chk i_chk (.sys_clk_i, .nrst_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .prdata_o, .pready_o, .pslverr_o, .conv_i, .core_req_o, .sample_cycles_o,
    .cmp_irq_o);

// ---- test/adsq_core_model.sv ----
`timescale 1ns/1ps
// Behavioural analog core: hands back one result per sample request.
module adsq_core_model (
    input wire logic sys_clk_i,
    input wire adsq_pkg::adsq_core_req_type req_i,
    input wire logic [3:0] smp_i,
    input wire logic slow_i,
    input wire logic [9:0] value_i,
    output adsq_pkg::adsq_conv_type conv_o
);
    import adsq_pkg::*;
    int cnt = 0; // Cycles left until the result is returned.
    // Delay covers sampling, discharge and conversion; slow mode stretches it.
    always @(posedge sys_clk_i) begin
        conv_o.valid <= 1'h0;
        conv_o.data <= ~conv_o.data; // Data wanders so stale values are never trusted.
        if (req_i.start) begin
            cnt <= 3 + int'(smp_i) + (slow_i ? 8 : 0);
        end else if (cnt == 1) begin
            conv_o.valid <= 1'h1;
            conv_o.data <= value_i;
            cnt <= 0;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end
    end
endmodule

// ---- test/tb.sv ----
`timescale 1ns/1ps
// Self-checking bench for the sequencer control slice.
module tb;
    import adsq_pkg::*;
    typedef struct packed {
        logic [7:0] cfg;
        logic [3:0] ded;
        logic [15:0] ana;
        logic trig;
        logic [3:0] smp;
    } adsq_row_type;
    logic sys_clk_i = 1'h0;
    logic nrst_i = 1'h0;
    logic psel = 1'h0, pen = 1'h0, pwr = 1'h0, slow = 1'h0, tenb = 1'h0;
    logic [2:0] chan = 3'h0;
    logic pready, pslverr, etrig, cmpirq, irq, er;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] pstrb = 4'hF, tded = 4'h0, smp;
    logic [15:0] tana = 16'h0000;
    logic [9:0] value = 10'h000;
    adsq_conv_type conv;
    adsq_core_req_type req;
    int error_cnt = 0, compares = 0, cycles = 0, cmp_cnt = 0;
    // Trigger selection rows; the last has an absent dedicated input.
    adsq_row_type rows [5] = '{'{8'h03, 4'h0, 16'h0008, 1'h1, 4'h0},
        '{8'h13, 4'h0, 16'h0000, 1'h0, 4'h2}, '{8'h83, 4'h8, 16'h0000, 1'h1, 4'h0},
        '{8'h83, 4'h0, 16'h0008, 1'h0, 4'h0}, '{8'h85, 4'hF, 16'h0000, 1'h0, 4'h0}};
    always #5 sys_clk_i = ~sys_clk_i;
    adsq_ctrl i_dut (.sys_clk_i, .nrst_i, .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
        .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .conv_i(conv), .trig_dedicated_i(tded),
        .trig_analog_i(tana), .core_req_o(req), .sample_cycles_o(smp), .ext_trig_o(etrig),
        .cmp_irq_o(cmpirq), .irq_o(irq));
    adsq_core_model i_core (.sys_clk_i, .req_i(req), .smp_i(smp), .slow_i(slow),
        .value_i(value), .conv_o(conv));
    // Pulses are caught here since a poll could miss them; also the hang limit.
    always @(posedge sys_clk_i) begin
        if (cmpirq === 1'h1) cmp_cnt <= cmp_cnt + 1;
        if (req.start === 1'h1) tenb <= req.ten_bit;
        if (req.start === 1'h1) chan <= req.channel;
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            test_done();
        end
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        compares++;
        if (s !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    // One APB transfer; the request is held until ready is sampled high.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        psel <= 1'h1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk_i);
        pen <= 1'h1;
        do begin
            @(posedge sys_clk_i);
        end while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        pen <= 1'h0;
    endtask
    // Start a sequence and poll the sequence-done event; only the hang limit bounds the wait.
    task automatic run(input logic [31:0] len);
        apb(1, 12'h038, 32'h3);
        apb(1, 12'h014, len);
        do begin
            apb(0, 12'h030, 0);
        end while (rd[0] !== 1'h1);
    endtask
    task automatic test_done;
        $display("Checks %0d, mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        int n;
        repeat (20) @(posedge sys_clk_i);
        nrst_i <= 1'h1;
        apb(0, 12'h004, 0);
        chk("cfg reset", {24'h0, ADSQ_CFG_RST}, rd);
        apb(0, 12'h028, 0);
        chk("flags reset", {24'h0, ADSQ_FLAGS_RST}, rd);
        foreach (rows[i]) begin
            tded <= rows[i].ded;
            tana <= rows[i].ana;
            apb(1, 12'h004, {24'h0, rows[i].cfg});
            repeat (2) @(posedge sys_clk_i);
            chk("ext_trig", {31'h0, rows[i].trig}, {31'h0, etrig});
            chk("sample_cycles", {28'h0, rows[i].smp}, {28'h0, smp});
            apb(0, 12'h004, 0);
            chk("cfg", {24'h0, rows[i].cfg}, rd);
        end
        // Eight-bit mode keeps only the upper result bits.
        apb(1, 12'h004, 32'h00);
        value <= 10'h2A7;
        run(1);
        chk("ten_bit off", 0, tenb);
        apb(0, 12'h040, 0);
        chk("result 8b", 32'h2A4, rd);
        apb(1, 12'h004, 32'h20);
        value <= 10'h2A5;
        run(2);
        chk("ten_bit on", 1, tenb);
        chk("channel", 1, chan);
        apb(0, 12'h028, 0);
        chk("flags two", 32'h03, rd);
        apb(0, 12'h044, 0);
        chk("result1", 32'h2A5, rd);
        apb(1, 12'h028, 32'h0);
        apb(1, 12'h028, 32'h1);
        apb(0, 12'h028, 0);
        chk("w1c", 32'h02, rd);
        slow <= 1'h1;
        apb(1, 12'h014, 1);
        apb(0, 12'h028, 0);
        chk("start clears", 0, rd);
        apb(1, 12'h004, 32'h20);
        n = 0;
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (conv.valid !== 1'h1 && n < 40);
        apb(0, 12'h028, 0);
        chk("abort", 0, rd);
        slow <= 1'h0;
        // Compare on position 0, greater-than, with compare irq enabled.
        apb(1, 12'h040, 32'h100);
        apb(1, 12'h020, 32'h101);
        apb(1, 12'h02C, 32'h2);
        value <= 10'h200;
        run(1);
        apb(0, 12'h028, 0);
        chk("cmp true", 32'h01, rd);
        chk("cmp irq", 1, cmp_cnt);
        apb(0, 12'h040, 0);
        chk("cmp value kept", 32'h100, rd);
        value <= 10'h050;
        run(1);
        apb(0, 12'h028, 0);
        chk("cmp false", 0, rd);
        chk("cmp irq once", 1, cmp_cnt);
        // Fast clear: result write clears a compare flag, read a normal one.
        apb(1, 12'h02C, 32'h1);
        value <= 10'h200;
        run(1);
        apb(1, 12'h040, 32'h100);
        apb(0, 12'h028, 0);
        chk("fast wr", 0, rd);
        chk("cmp irq masked", 1, cmp_cnt);
        apb(1, 12'h020, 32'h0);
        apb(1, 12'h034, 32'h0);
        run(1);
        repeat (2) @(posedge sys_clk_i);
        chk("irq masked", 0, irq);
        apb(0, 12'h040, 0);
        apb(0, 12'h028, 0);
        chk("fast rd", 0, rd);
        apb(1, 12'h034, 32'h1);
        repeat (2) @(posedge sys_clk_i);
        chk("irq on", 1, irq);
        apb(1, 12'h038, 32'h1);
        repeat (2) @(posedge sys_clk_i);
        chk("irq cleared", 0, irq);
        apb(0, 12'h100, 0);
        chk("unmapped", 1, er);
        // A reset after a finished run brings back the reset values.
        apb(1, 12'h004, 32'h13);
        run(1);
        nrst_i <= 1'h0;
        repeat (3) @(posedge sys_clk_i);
        nrst_i <= 1'h1;
        apb(0, 12'h004, 0);
        chk("cfg after reset", {24'h0, ADSQ_CFG_RST}, rd);
        apb(0, 12'h028, 0);
        chk("flags after reset", {24'h0, ADSQ_FLAGS_RST}, rd);
        chk("irq after reset", 0, irq);
        test_done();
    end
endmodule
